/* debug_port_pkg.sv */
// Constants and types for the debug port access-layer register block.
// Assumes a single 200 MHz system clock and byte-wide register access.
// Notes on behaviour
// (RULE1) With nack_suppress set, no NACK signature on system reset mid access
// (RULE2) With contention_check_off set, collision and contention checks stop
// (RULE3) Writing port_disable turns port off, drops clock request, resets keys
// (RULE4) Key status bit 5 shows the user row write key
// (RULE5) Key status bit 4 shows NVM programming key, cleared when done
// (RULE6) Key status bit 3 shows erase key, cleared when erase completes
// (RULE7) Writing 0x59 to reset request holds system reset; other values free
// (RULE8) Reset request reads bit 0 as the held reset, other bits zero
// (RULE9) The held system reset leaves the port's own logic untouched
// (RULE10) Clock select: 1=16 MHz, 2=8 MHz, 3=4 MHz, 0 reserved; default 4 MHz
// (RULE11) Debugger keeps 4 MHz unless brown-out detector is at top level
// (RULE12) Writing user_row_done starts user row flash programming, key needed
// (RULE13) Debugger loads user row data to RAM before writing user_row_done
// (RULE14) system_clock_request keeps system clock running through sleep
// (RULE15) system_clock_request sets on port enable, clears on port disable
// (RULE16) Status bit 5 shows system reset, including held reset; clear on read
// (RULE17) Status bit 4 shows system in idle or deeper sleep
// (RULE18) Debugger programs NVM only after status bit 3, then resets system
// (RULE19) Debugger programs user row only after status bit 2, then writes done
// (RULE20) Status bit 0 shows device locked; reset value one
// (RULE21) CRC status is one-hot: 0 off, 1 busy, 2 pass, 4 fail
// (RULE22) Reserved bits read zero and ignore writes
// (RULE23) Registers reachable only from the debug port, never from the CPU
package debug_port_pkg;

	localparam logic [3:0] OFS_PHY_CTRL_B = 4'h3;
	localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
	localparam logic [3:0] OFS_RESET_REQ = 4'h8;
	localparam logic [3:0] OFS_CLOCK_CTRL = 4'h9;
	localparam logic [3:0] OFS_SYS_CTRL = 4'hA;
	localparam logic [3:0] OFS_SYS_STATUS = 4'hB;
	localparam logic [3:0] OFS_CRC_STATUS = 4'hC;

	localparam int BIT_NACK_SUPPRESS = 4;
	localparam int BIT_CONTENTION_OFF = 3;
	localparam int BIT_PORT_DISABLE = 2;
	localparam int BIT_KEY_USER_ROW = 5;
	localparam int BIT_KEY_NVM = 4;
	localparam int BIT_KEY_ERASE = 3;
	localparam int BIT_RESET_HELD = 0;
	localparam int BIT_USER_ROW_DONE = 1;
	localparam int BIT_CLOCK_REQUEST = 0;
	localparam int BIT_ST_RESET = 5;
	localparam int BIT_ST_SLEEP = 4;
	localparam int BIT_ST_NVM_OK = 3;
	localparam int BIT_ST_ROW_OK = 2;
	localparam int BIT_ST_LOCKED = 0;

	localparam logic [7:0] RESET_SIGNATURE = 8'h59;

	localparam logic [1:0] CLKSEL_RESERVED = 2'h0;
	localparam logic [1:0] CLKSEL_16MHZ = 2'h1;
	localparam logic [1:0] CLKSEL_8MHZ = 2'h2;
	localparam logic [1:0] CLKSEL_4MHZ = 2'h3;
	localparam logic [1:0] CLKSEL_RESET = CLKSEL_4MHZ;

	localparam logic [7:0] SYS_CLK_MHZ = 8'hC8;
	localparam logic [7:0] PORT_16_MHZ = 8'h10;
	localparam logic [7:0] PORT_8_MHZ = 8'h08;
	localparam logic [7:0] PORT_4_MHZ = 8'h04;

	localparam logic [2:0] CRC_OFF = 3'h0;
	localparam logic [2:0] CRC_BUSY = 3'h1;
	localparam logic [2:0] CRC_PASS = 3'h2;
	localparam logic [2:0] CRC_FAIL = 3'h4;

	localparam logic LOCKED_RESET = 1'b1;
	localparam logic [7:0] READ_ZERO = 8'h00;

	typedef enum logic [1:0] {
		PORT_OFF = 2'b01,
		PORT_ON = 2'b10
	} port_state_e;

endpackage : debug_port_pkg

/* port_clock_gen.sv */
// Fractional divider making the port clock tick from the system clock.
// Assumes the select code is one of the three legal rates.
`timescale 1ns/1ps
module port_clock_gen (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input wire logic [1:0] select_in,
	output logic tick_out
);
	import debug_port_pkg::*;

	typedef struct packed {
		logic [7:0] acc;
		logic tick;
	} gen_s;

	gen_s st;
	gen_s next_st;
	logic [7:0] step;
	logic [7:0] sum;

	// 200 is not a multiple of 16, so a phase accumulator spaces the ticks
	always_comb begin
		case (select_in)
			CLKSEL_16MHZ: step = PORT_16_MHZ; // [RULE10]
			CLKSEL_8MHZ: step = PORT_8_MHZ; // [RULE10]
			default: step = PORT_4_MHZ; // [RULE10]
		endcase
		sum = st.acc + step;
		next_st = st;
		next_st.tick = 1'b0;
		if (!enable_in) begin
			next_st.acc = 8'h00;
		end else if (sum >= SYS_CLK_MHZ) begin
			next_st.acc = sum - SYS_CLK_MHZ;
			next_st.tick = 1'b1;
		end else begin
			next_st.acc = sum;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;

endmodule : port_clock_gen

/* debug_port_access_control.sv */
// Access-layer control and status registers of the single pin debug port.
// Assumes the frame decoder presents byte register accesses and key pulses,
// and that all system-domain inputs are synchronous to clk_sys_in.
`timescale 1ns/1ps
module debug_port_access_control (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic port_enable_in,
	input wire logic reg_read_in,
	input wire logic reg_write_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic user_row_key_set_in,
	input wire logic nvm_key_set_in,
	input wire logic erase_key_set_in,
	input wire logic nvm_program_done_in,
	input wire logic erase_done_in,
	input wire logic access_busy_in,
	input wire logic system_in_reset_in,
	input wire logic system_sleeping_in,
	input wire logic nvm_program_ok_in,
	input wire logic user_row_program_ok_in,
	input wire logic device_locked_in,
	input wire logic [2:0] crc_state_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic port_enabled_out,
	output logic contention_check_en_out,
	output logic nack_send_out,
	output logic nack_suppress_out,
	output logic system_reset_out,
	output logic system_clock_request_out,
	output logic user_row_start_out,
	output logic user_row_key_active_out,
	output logic nvm_program_key_out,
	output logic erase_all_key_out,
	output logic [1:0] port_clock_select_out,
	output logic port_clock_tick_out
);
	import debug_port_pkg::*;

	typedef struct packed {
		port_state_e port;
		logic enabled;
		logic nack_suppress;
		logic contention_off;
		logic port_disable;
		logic contention_en;
		logic [1:0] clock_select;
		logic user_row_key;
		logic nvm_key;
		logic erase_key;
		logic reset_hold;
		logic clock_request;
		logic user_row_done;
		logic user_row_start;
		logic reset_seen;
		logic sys_reset_q;
		logic nack_send;
		logic locked;
		logic [2:0] crc;
		logic [7:0] rdata;
		logic rvalid;
	} ctrl_s;

	ctrl_s st;
	ctrl_s next_st;
	logic is_on;
	logic wr_ctrl_b;
	logic wr_key;
	logic wr_reset;
	logic wr_clock;
	logic wr_sys;
	logic rd_status;
	logic reset_now;
	logic [7:0] status_view;
	logic [7:0] read_mux;

	// Only the debug port's own register path reaches these; no CPU bus
	// connection exists by construction. [RULE23]
	always_comb begin
		is_on = (st.port == PORT_ON);
		wr_ctrl_b = reg_write_in && reg_addr_in == OFS_PHY_CTRL_B;
		wr_key = reg_write_in && reg_addr_in == OFS_KEY_STATUS;
		wr_reset = reg_write_in && reg_addr_in == OFS_RESET_REQ;
		wr_clock = reg_write_in && reg_addr_in == OFS_CLOCK_CTRL;
		wr_sys = reg_write_in && reg_addr_in == OFS_SYS_CTRL;
		rd_status = reg_read_in && reg_addr_in == OFS_SYS_STATUS;
		reset_now = system_in_reset_in || st.reset_hold;

		status_view = READ_ZERO;
		status_view[BIT_ST_RESET] = st.reset_seen || reset_now; // [RULE16]
		status_view[BIT_ST_SLEEP] = system_sleeping_in; // [RULE17]
		status_view[BIT_ST_NVM_OK] = nvm_program_ok_in;
		status_view[BIT_ST_ROW_OK] = user_row_program_ok_in;
		status_view[BIT_ST_LOCKED] = st.locked; // [RULE20]

		// Unlisted bits and unmapped offsets read zero [RULE22]
		read_mux = READ_ZERO;
		case (reg_addr_in)
			OFS_PHY_CTRL_B: begin
				read_mux[BIT_NACK_SUPPRESS] = st.nack_suppress;
				read_mux[BIT_CONTENTION_OFF] = st.contention_off;
				read_mux[BIT_PORT_DISABLE] = st.port_disable;
			end
			OFS_KEY_STATUS: begin
				read_mux[BIT_KEY_USER_ROW] = st.user_row_key; // [RULE4]
				read_mux[BIT_KEY_NVM] = st.nvm_key; // [RULE5]
				read_mux[BIT_KEY_ERASE] = st.erase_key; // [RULE6]
			end
			OFS_RESET_REQ: begin
				read_mux[BIT_RESET_HELD] = st.reset_hold; // [RULE8]
			end
			OFS_CLOCK_CTRL: begin
				read_mux[1:0] = st.clock_select;
			end
			OFS_SYS_CTRL: begin
				read_mux[BIT_USER_ROW_DONE] = st.user_row_done;
				read_mux[BIT_CLOCK_REQUEST] = st.clock_request;
			end
			OFS_SYS_STATUS: begin
				read_mux = status_view;
			end
			OFS_CRC_STATUS: begin
				read_mux[2:0] = st.crc;
			end
			default: begin
				read_mux = READ_ZERO;
			end
		endcase

		next_st = st;
		next_st.rvalid = reg_read_in;
		next_st.rdata = reg_read_in ? read_mux : READ_ZERO;
		next_st.user_row_start = 1'b0;
		next_st.nack_send = 1'b0;
		next_st.sys_reset_q = system_in_reset_in;
		next_st.locked = device_locked_in; // [RULE20]

		// Reserved codes are never passed on, so software sees only legal ones
		case (crc_state_in)
			CRC_OFF, CRC_BUSY, CRC_PASS, CRC_FAIL: begin
				next_st.crc = crc_state_in; // [RULE21]
			end
			default: begin
				next_st.crc = CRC_OFF; // [RULE21]
			end
		endcase

		// A fresh reset in the same cycle as the read still shows next time
		next_st.reset_seen = (st.reset_seen && !rd_status)
			|| reset_now; // [RULE16]

		// A NACK is only due for a reset edge that hits a running access
		if (is_on && system_in_reset_in && !st.sys_reset_q
			&& access_busy_in && !st.nack_suppress) begin
			next_st.nack_send = 1'b1; // [RULE1]
		end

		// The held system reset is kept apart from nrst_in, so the
		// port's own state survives it [RULE9]
		if (wr_reset) begin
			next_st.reset_hold =
				(reg_wdata_in == RESET_SIGNATURE); // [RULE7]
		end

		case (st.port)
			PORT_OFF: begin
				if (port_enable_in) begin
					next_st.port = PORT_ON;
					next_st.port_disable = 1'b0;
					next_st.clock_request = 1'b1; // [RULE15]
					next_st.clock_select = CLKSEL_RESET; // [RULE10]
				end
			end
			PORT_ON: begin
				if (wr_ctrl_b && reg_wdata_in[BIT_PORT_DISABLE]) begin
					next_st.port = PORT_OFF; // [RULE3]
					next_st.port_disable = 1'b1;
					next_st.nack_suppress = 1'b0; // [RULE3]
					next_st.contention_off = 1'b0; // [RULE3]
					next_st.clock_select = CLKSEL_RESET; // [RULE3]
					next_st.clock_request = 1'b0; // [RULE3] [RULE15]
					next_st.user_row_key = 1'b0; // [RULE3]
					next_st.nvm_key = 1'b0; // [RULE3]
					next_st.erase_key = 1'b0; // [RULE3]
					next_st.user_row_done = 1'b0;
				end else begin
					if (wr_ctrl_b) begin
						next_st.nack_suppress =
							reg_wdata_in[BIT_NACK_SUPPRESS]; // [RULE1]
						next_st.contention_off =
							reg_wdata_in[BIT_CONTENTION_OFF]; // [RULE2]
					end
					// A reserved code would stall the port, so it is ignored
					if (wr_clock
						&& reg_wdata_in[1:0] != CLKSEL_RESERVED) begin
						next_st.clock_select = reg_wdata_in[1:0]; // [RULE10]
					end
					if (wr_sys) begin
						next_st.clock_request =
							reg_wdata_in[BIT_CLOCK_REQUEST]; // [RULE14]
						if (st.user_row_key) begin
							next_st.user_row_done =
								reg_wdata_in[BIT_USER_ROW_DONE]; // [RULE12]
							next_st.user_row_start =
								reg_wdata_in[BIT_USER_ROW_DONE]; // [RULE12]
						end
					end
					// Software may drop the user row key; a decode wins
					if (wr_key && !reg_wdata_in[BIT_KEY_USER_ROW]) begin
						next_st.user_row_key = 1'b0;
						next_st.user_row_done = 1'b0;
					end
					if (user_row_key_set_in) begin
						next_st.user_row_key = 1'b1; // [RULE4]
					end
					if (nvm_program_done_in) begin
						next_st.nvm_key = 1'b0; // [RULE5]
					end
					if (nvm_key_set_in) begin
						next_st.nvm_key = 1'b1; // [RULE5]
					end
					if (erase_done_in) begin
						next_st.erase_key = 1'b0; // [RULE6]
					end
					if (erase_key_set_in) begin
						next_st.erase_key = 1'b1; // [RULE6]
					end
				end
			end
			default: begin
				next_st.port = PORT_OFF;
			end
		endcase

		next_st.contention_en = (next_st.port == PORT_ON)
			&& !next_st.contention_off; // [RULE2]
		// Kept as its own flop so the pin is not a state decode
		next_st.enabled = (next_st.port == PORT_ON);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= '0;
			st.port <= PORT_OFF;
			st.clock_select <= CLKSEL_RESET;
			st.locked <= LOCKED_RESET;
		end else begin
			st <= next_st;
		end
	end

	port_clock_gen u_port_clock_gen (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.enable_in(is_on),
		.select_in(st.clock_select),
		.tick_out(port_clock_tick_out)
	);

	assign reg_rdata_out = st.rdata;
	assign reg_rvalid_out = st.rvalid;
	assign port_enabled_out = st.enabled;
	assign contention_check_en_out = st.contention_en;
	assign nack_send_out = st.nack_send;
	assign nack_suppress_out = st.nack_suppress;
	assign system_reset_out = st.reset_hold; // [RULE7]
	assign system_clock_request_out = st.clock_request; // [RULE14]
	assign user_row_start_out = st.user_row_start;
	assign user_row_key_active_out = st.user_row_key;
	assign nvm_program_key_out = st.nvm_key;
	assign erase_all_key_out = st.erase_key;
	assign port_clock_select_out = st.clock_select;

endmodule : debug_port_access_control

/* debug_port_checker_assertions.sv */
// Port-level checks of the debug port access-control register block.
// Assumes one clock domain and a bind by name onto the top module.
`timescale 1ns/1ps
module debug_port_checker (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic port_enable_in,
	input wire logic reg_read_in,
	input wire logic reg_write_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic nvm_program_done_in,
	input wire logic nvm_key_set_in,
	input wire logic access_busy_in,
	input wire logic system_in_reset_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic port_enabled_out,
	input wire logic contention_check_en_out,
	input wire logic nack_send_out,
	input wire logic nack_suppress_out,
	input wire logic system_reset_out,
	input wire logic system_clock_request_out,
	input wire logic user_row_start_out,
	input wire logic user_row_key_active_out,
	input wire logic nvm_program_key_out,
	input wire logic [1:0] port_clock_select_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	logic wr_on;
	logic row_req;
	// Writes only count while the port is on
	assign wr_on = reg_write_in && port_enabled_out;
	assign row_req = wr_on && reg_addr_in == 4'hA && reg_wdata_in[1]
		&& user_row_key_active_out;
	hold_reset_a: assert property (wr_on && reg_addr_in == 4'h8
		|=> system_reset_out == ($past(reg_wdata_in) == 8'h59))
		else $error("held reset does not follow signature write");
	reset_readback_a: assert property (
		reg_read_in && reg_addr_in == 4'h8 |=> reg_rvalid_out
		&& reg_rdata_out == {7'h00, $past(system_reset_out)})
		else $error("reset request readback wrong");
	port_off_a: assert property (
		wr_on && reg_addr_in == 4'h3 && reg_wdata_in[2] |=> !port_enabled_out
		&& !system_clock_request_out && !user_row_key_active_out)
		else $error("disable left port or key active");
	port_on_a: assert property (
		!port_enabled_out && port_enable_in |=> port_enabled_out
		&& system_clock_request_out && port_clock_select_out == 2'h3)
		else $error("enable did not set defaults");
	nack_send_a: assert property (
		port_enabled_out && access_busy_in && !nack_suppress_out
		&& $rose(system_in_reset_in) |=> nack_send_out)
		else $error("no nack on reset during access");
	nack_quiet_a: assert property (
		nack_suppress_out && $rose(system_in_reset_in) |=> !nack_send_out)
		else $error("nack sent while suppressed");
	contention_off_a: assert property (
		wr_on && reg_addr_in == 4'h3 && reg_wdata_in[3]
		|=> !contention_check_en_out)
		else $error("contention check still on");
	row_start_a: assert property (
		user_row_start_out == $past(row_req))
		else $error("user row start mismatch");
	clock_req_a: assert property (wr_on && reg_addr_in == 4'hA
		|=> {7'h00, system_clock_request_out} == ($past(reg_wdata_in) & 8'h01))
		else $error("clock request does not follow write");
	nvm_clear_a: assert property (
		nvm_program_done_in && !nvm_key_set_in |=> !nvm_program_key_out)
		else $error("programming key not cleared");
	cover property (nack_send_out);
	cover property (user_row_start_out);
	cover property (system_reset_out && system_in_reset_in);
endmodule : debug_port_checker

bind debug_port_access_control debug_port_checker u_debug_port_checker (.*);

/* sys_domain_model.sv */
// Behavioural system domain: follows the held reset, finishes key sequences.
// Assumes the same clock and reset as the register block.
`timescale 1ns/1ps
module sys_domain_model (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic reset_req_in,
	input wire logic nvm_key_in,
	input wire logic erase_key_in,
	output logic in_reset_out,
	output logic nvm_done_out,
	output logic erase_done_out
);
	logic [2:0] nvm_cnt;
	logic [2:0] erase_cnt;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			nvm_cnt <= 3'h0;
			erase_cnt <= 3'h0;
			in_reset_out <= 1'b0;
			nvm_done_out <= 1'b0;
			erase_done_out <= 1'b0;
		end else begin
			// Reset reaches the system one cycle late, as a real tree would
			in_reset_out <= reset_req_in;
			nvm_cnt <= nvm_key_in ? nvm_cnt + 3'h1 : 3'h0;
			erase_cnt <= erase_key_in ? erase_cnt + 3'h1 : 3'h0;
			nvm_done_out <= nvm_cnt == 3'h5;
			erase_done_out <= erase_cnt == 3'h6;
		end
	end
endmodule : sys_domain_model

/* tb_debug_port_access_control.sv */
// Register-level test of the debug port access-control block.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module tb_debug_port_access_control;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic port_enable_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic reg_write_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic user_row_key_set_in = 1'b0;
	logic nvm_key_set_in = 1'b0;
	logic erase_key_set_in = 1'b0;
	logic access_busy_in = 1'b0;
	logic system_sleeping_in = 1'b0;
	logic nvm_program_ok_in = 1'b0;
	logic user_row_program_ok_in = 1'b0;
	logic device_locked_in = 1'b1;
	logic [2:0] crc_state_in = 3'h0;
	logic nvm_program_done_in, erase_done_in, system_in_reset_in;
	logic [7:0] reg_rdata_out;
	logic reg_rvalid_out, port_enabled_out, contention_check_en_out;
	logic nack_send_out, nack_suppress_out, system_reset_out;
	logic system_clock_request_out, user_row_start_out, port_clock_tick_out;
	logic user_row_key_active_out, nvm_program_key_out, erase_all_key_out;
	logic [1:0] port_clock_select_out;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] e;
	logic [7:0] cs [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
	logic [2:0] crc [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	always #2.5 clk_sys_in = ~clk_sys_in;
	// One-cycle pulses are counted here so no task has to catch them
	logic [7:0] n_nack = 8'h00;
	logic [7:0] n_row = 8'h00;
	always @(posedge clk_sys_in) begin
		if (nack_send_out === 1'b1)
			n_nack <= n_nack + 8'h01;
		if (user_row_start_out === 1'b1)
			n_row <= n_row + 8'h01;
	end
	debug_port_access_control u_debug_port_access_control (.*);
	sys_domain_model u_sys_domain_model (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.reset_req_in(system_reset_out),
		.nvm_key_in(nvm_program_key_out),
		.erase_key_in(erase_all_key_out),
		.in_reset_out(system_in_reset_in),
		.nvm_done_out(nvm_program_done_in),
		.erase_done_out(erase_done_in)
	);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_write_in <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_read_in <= 1'b0;
		#1;
		cmp({7'h00, reg_rvalid_out}, 8'h01);
		cmp(reg_rdata_out, exp);
	endtask : rd
	// Bounded wait for the system model to finish a key sequence
	task automatic drain;
		for (int i = 0; i < 20; i++)
			if (nvm_program_key_out || erase_all_key_out) @(posedge clk_sys_in);
	endtask : drain
	// 200 system cycles are 1 us, so the tick count equals the rate in MHz
	task automatic ticks(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		repeat (200) begin
			@(posedge clk_sys_in);
			if (port_clock_tick_out === 1'b1)
				n++;
		end
		cmp(n, exp);
	endtask : ticks
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		#20000;
		errors++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rd(4'hB, 8'h01);
		wr(4'h9, 8'h01);
		rd(4'h9, 8'h03);
		@(posedge clk_sys_in) port_enable_in <= 1'b1;
		@(posedge clk_sys_in) port_enable_in <= 1'b0;
		rd(4'hA, 8'h01);
		ticks(8'h04);
		// Faster rates below assume the brown-out detector at top level
		e = 8'h03;
		foreach (cs[i]) begin
			wr(4'h9, cs[i]);
			if (cs[i] != 8'h00) e = cs[i];
			rd(4'h9, e);
		end
		wr(4'h9, 8'hFD);
		rd(4'h9, 8'h01);
		ticks(8'h10);
		@(posedge clk_sys_in) access_busy_in <= 1'b1;
		wr(4'h8, 8'h59);
		cmp({7'h00, system_reset_out}, 8'h01);
		rd(4'h8, 8'h01);
		rd(4'h9, 8'h01);
		cmp(n_nack, 8'h01);
		wr(4'h8, 8'h58);
		rd(4'h8, 8'h00);
		rd(4'hB, 8'h21);
		rd(4'hB, 8'h01);
		wr(4'h3, 8'h10);
		cmp({7'h00, nack_suppress_out}, 8'h01);
		wr(4'h8, 8'h59);
		wr(4'h8, 8'h00);
		@(posedge clk_sys_in) access_busy_in <= 1'b0;
		rd(4'hB, 8'h21);
		cmp(n_nack, 8'h01);
		@(posedge clk_sys_in) begin
			system_sleeping_in <= 1'b1;
			nvm_program_ok_in <= 1'b1;
			user_row_program_ok_in <= 1'b1;
			device_locked_in <= 1'b0;
		end
		rd(4'hB, 8'h1C);
		foreach (crc[i]) begin
			@(posedge clk_sys_in) crc_state_in <= crc[i];
			rd(4'hC, {5'h00, crc[i]});
		end
		@(posedge clk_sys_in) crc_state_in <= 3'h3;
		rd(4'hC, 8'h00);
		wr(4'hA, 8'h03);
		rd(4'hA, 8'h01);
		cmp(n_row, 8'h00);
		@(posedge clk_sys_in) user_row_key_set_in <= 1'b1;
		@(posedge clk_sys_in) user_row_key_set_in <= 1'b0;
		rd(4'h7, 8'h20);
		cmp({7'h00, user_row_key_active_out}, 8'h01);
		wr(4'hA, 8'h03);
		rd(4'hA, 8'h03);
		cmp(n_row, 8'h01);
		wr(4'h7, 8'h00);
		rd(4'h7, 8'h00);
		@(posedge clk_sys_in) nvm_key_set_in <= 1'b1;
		@(posedge clk_sys_in) nvm_key_set_in <= 1'b0;
		rd(4'h7, 8'h10);
		cmp({7'h00, nvm_program_key_out}, 8'h01);
		drain();
		rd(4'h7, 8'h00);
		wr(4'h8, 8'h59);
		wr(4'h8, 8'h00);
		@(posedge clk_sys_in) erase_key_set_in <= 1'b1;
		@(posedge clk_sys_in) erase_key_set_in <= 1'b0;
		rd(4'h7, 8'h08);
		cmp({7'h00, erase_all_key_out}, 8'h01);
		drain();
		rd(4'h7, 8'h00);
		wr(4'h3, 8'h08);
		cmp({7'h00, contention_check_en_out}, 8'h00);
		@(posedge clk_sys_in) user_row_key_set_in <= 1'b1;
		@(posedge clk_sys_in) user_row_key_set_in <= 1'b0;
		wr(4'h3, 8'h04);
		cmp({7'h00, port_enabled_out}, 8'h00);
		cmp({7'h00, system_clock_request_out}, 8'h00);
		rd(4'h7, 8'h00);
		rd(4'h9, 8'h03);
		cmp({6'h00, port_clock_select_out}, 8'h03);
		rd(4'h3, 8'h04);
		ticks(8'h00);
		conclude();
	end
endmodule : tb_debug_port_access_control
